// ### ls_pkg.sv
package ls_pkg;
   // register indices on the serial bus
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h01;
   localparam logic [7:0] ADDR_RECV_CFG = 8'h02;
   localparam logic [7:0] ADDR_RESULT_HI = 8'h04;
   localparam logic [7:0] ADDR_RESULT_LO = 8'h05;
   localparam logic [7:0] ADDR_UPPER_HI = 8'h06;
   localparam logic [7:0] ADDR_UPPER_LO = 8'h07;
   localparam logic [7:0] ADDR_LOWER_HI = 8'h08;
   localparam logic [7:0] ADDR_LOWER_LO = 8'h09;
   localparam logic [7:0] ADDR_PERSIST = 8'h0a;
   localparam logic [7:0] ADDR_GREEN_ADJ = 8'h0f;
   localparam logic [7:0] ADDR_IR_ADJ = 8'h10;
   // reset values
   localparam logic [7:0] RST_STATUS = 8'h04;
   localparam logic [7:0] RST_MAIN_CFG = 8'h24;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_GAIN_ADJ = 8'h80;
   // writable bit masks, reserved bits read zero
   localparam logic [7:0] MASK_MAIN_CFG = 8'h2d;
   localparam logic [7:0] MASK_RECV_CFG = 8'h0f;
   localparam logic [7:0] MASK_HIGH_BYTE = 8'h3f;
   localparam logic [7:0] MASK_PERSIST = 8'h03;
   // field positions
   localparam int STAT_WIN_BIT = 0;
   localparam int STAT_PWR_BIT = 2;
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_MODE_LSB = 2;
   localparam int CFG_TRIM_BIT = 5;
   localparam int RES_OVF_BIT = 6;
   // operating modes
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_GREEN_MINUS_IR = 2'h1;
   localparam logic [1:0] MODE_GREEN = 2'h2;
   localparam logic [1:0] MODE_IR = 2'h3;
   // result arithmetic
   localparam int RESULT_W = 14;
   localparam logic [22:0] RESULT_MAX = 23'h003fff;
   localparam int GREEN_SHIFT = 6;
   localparam int IR_SHIFT = 8;
   // consecutive out-of-window samples needed per persist setting
   localparam logic [4:0] PERSIST_N0 = 5'h01;
   localparam logic [4:0] PERSIST_N1 = 5'h04;
   localparam logic [4:0] PERSIST_N2 = 5'h08;
   localparam logic [4:0] PERSIST_N3 = 5'h10;
   localparam logic [3:0] I2C_BITS = 4'h8;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_RACK} ls_i2c_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ls_req_s;

   typedef struct packed {
      logic [7:0] main_cfg;
      logic [7:0] recv_cfg;
      logic [7:0] upper_hi;
      logic [7:0] upper_lo;
      logic [7:0] lower_hi;
      logic [7:0] lower_lo;
      logic [7:0] persist;
      logic [7:0] green_adj;
      logic [7:0] ir_adj;
   } ls_regs_s;
endpackage

// ### ls_i2c_target.sv
`timescale 1ns/1ps
module ls_i2c_target import ls_pkg::*; #(
   parameter logic [6:0] TARGET_BASE = 7'h2a // arbitrary, bit 0 comes from the pin
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // synchronised bus pins
   input wire logic scl_s,
   input wire logic sda_s,
   input wire logic addr_sel,
   output logic sda_oe,
   // register access
   output ls_req_s req,
   input wire logic [7:0] rd_data
);
   ls_i2c_state_e state, next_state;
   logic [7:0] shreg, next_shreg;
   logic [7:0] ptr, next_ptr;
   logic [3:0] bitcnt, next_bitcnt;
   logic rw, next_rw;
   logic first, next_first;
   logic next_sda_oe;
   logic scl_d, sda_d;
   logic rise, fall, start, stop;

   assign rise = scl_s & ~scl_d;
   assign fall = ~scl_s & scl_d;
   assign start = scl_s & scl_d & sda_d & ~sda_s;
   assign stop = scl_s & scl_d & ~sda_d & sda_s;

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_ptr = ptr;
      next_bitcnt = bitcnt;
      next_rw = rw;
      next_first = first;
      next_sda_oe = sda_oe;
      req = '0;
      if (stop) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end else if (start) begin
         next_state = ST_ADDR;
         next_bitcnt = '0;
         next_first = 1'b1;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            ST_ADDR, ST_RX: begin
               if (rise) begin
                  next_shreg = {shreg[6:0], sda_s};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (fall && bitcnt == I2C_BITS) begin
                  next_bitcnt = '0;
                  next_sda_oe = 1'b1;
                  next_state = ST_ACK;
                  if (state == ST_ADDR) begin
                     next_rw = shreg[0];
                     if (shreg[7:1] != {TARGET_BASE[6:1], addr_sel}) begin
                        next_sda_oe = 1'b0;
                        next_state = ST_IDLE;
                     end
                  end else if (first) begin
                     next_ptr = shreg;
                     next_first = 1'b0;
                  end else begin
                     req.wr = 1'b1;
                     req.addr = ptr;
                     req.wdata = shreg;
                     next_ptr = ptr + 8'h01;
                  end
               end
            end
            ST_ACK, ST_RACK: begin
               if (state == ST_RACK && rise && sda_s) begin
                  // host refused the byte: end of read
                  next_state = ST_IDLE;
               end else if (fall) begin
                  next_sda_oe = 1'b0;
                  next_bitcnt = '0;
                  next_state = ST_RX;
                  if (rw) begin
                     req.rd = 1'b1;
                     req.addr = ptr;
                     next_shreg = rd_data;
                     next_sda_oe = ~rd_data[7];
                     next_ptr = ptr + 8'h01;
                     next_state = ST_TX;
                  end
               end
            end
            ST_TX: begin
               if (rise) begin
                  next_bitcnt = bitcnt + 4'h1;
               end else if (fall) begin
                  if (bitcnt == I2C_BITS) begin
                     next_sda_oe = 1'b0;
                     next_state = ST_RACK;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_sda_oe = ~shreg[6];
                  end
               end
            end
            ST_IDLE: next_sda_oe = 1'b0;
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_IDLE;
         shreg <= '0;
         ptr <= '0;
         bitcnt <= '0;
         rw <= 1'b0;
         first <= 1'b0;
         sda_oe <= 1'b0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         ptr <= next_ptr;
         bitcnt <= next_bitcnt;
         rw <= next_rw;
         first <= next_first;
         sda_oe <= next_sda_oe;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end
endmodule

// ### ls_light_regs.sv
`timescale 1ns/1ps
module ls_light_regs import ls_pkg::*; #(
   parameter logic [6:0] TARGET_BASE = 7'h2a, // arbitrary value
   parameter logic [6:0] FACTORY_GREEN = 7'h40,
   parameter logic [8:0] FACTORY_IR = 9'h100
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial bus pins
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   output logic sda_pin_out,
   output logic sda_pin_oe,
   input wire logic target_addr_select,
   // open-drain interrupt pin, active low
   output logic int_n_pin_out,
   output logic int_n_pin_oe,
   // converter side, same clock
   input wire logic [RESULT_W-1:0] green_raw,
   input wire logic [RESULT_W-1:0] infrared_raw,
   input wire logic sample_valid,
   output logic [1:0] op_mode,
   output logic [1:0] integration_time_select,
   output logic [1:0] front_gain_select
);
   logic scl_m, scl_s, sda_m, sda_s, sel_m, sel_s;
   ls_req_s req;
   logic [7:0] rd_data;
   ls_regs_s regs, next_regs;
   logic power_up_flag, next_power_up_flag;
   logic light_window_flag, next_light_window_flag;
   logic [RESULT_W-1:0] light_result, next_light_result;
   logic result_overflow, next_result_overflow;
   logic [4:0] persist_cnt, next_persist_cnt;
   logic [4:0] persist_need;
   logic [6:0] green_gain;
   logic [8:0] ir_gain;
   logic [22:0] green_scaled, ir_scaled, value;
   logic [RESULT_W-1:0] upper_limit, lower_limit, new_result;
   logic new_overflow, out_window, active_sample, status_read, window_hit;
   logic light_irq_enable, trim_select;

   // pins cross from the bus into the clock domain
   always_ff @(posedge clk) begin
      if (reset) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sel_m <= 1'b0;
         sel_s <= 1'b0;
      end else begin
         scl_m <= scl_pin;
         scl_s <= scl_m;
         sda_m <= sda_pin_in;
         sda_s <= sda_m;
         sel_m <= target_addr_select;
         sel_s <= sel_m;
      end
   end

   ls_i2c_target #(.TARGET_BASE(TARGET_BASE)) u_target (
      .clk(clk),
      .reset(reset),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .addr_sel(sel_s),
      .sda_oe(sda_pin_oe),
      .req(req),
      .rd_data(rd_data)
   );
   assign sda_pin_out = 1'b0;

   assign light_irq_enable = regs.main_cfg[CFG_EN_BIT];
   assign trim_select = regs.main_cfg[CFG_TRIM_BIT];
   assign op_mode = regs.main_cfg[CFG_MODE_LSB +: 2];
   assign integration_time_select = regs.recv_cfg[3:2];
   assign front_gain_select = regs.recv_cfg[1:0];
   assign upper_limit = {regs.upper_hi[5:0], regs.upper_lo};
   assign lower_limit = {regs.lower_hi[5:0], regs.lower_lo};
   assign status_read = req.rd && req.addr == ADDR_STATUS;

   // interrupt pin only ever pulls low; the board pull-up gives the high level
   assign int_n_pin_out = 1'b0;
   assign int_n_pin_oe = power_up_flag | light_window_flag;

   // read mux; the target module registers the byte before it leaves
   always_comb begin
      rd_data = '0;
      case (req.addr)
         ADDR_STATUS: begin
            rd_data[STAT_PWR_BIT] = power_up_flag;
            rd_data[STAT_WIN_BIT] = light_window_flag;
         end
         ADDR_MAIN_CFG: rd_data = regs.main_cfg;
         ADDR_RECV_CFG: rd_data = regs.recv_cfg;
         ADDR_RESULT_HI: rd_data = {1'b0, result_overflow, light_result[13:8]};
         ADDR_RESULT_LO: rd_data = light_result[7:0];
         ADDR_UPPER_HI: rd_data = regs.upper_hi;
         ADDR_UPPER_LO: rd_data = regs.upper_lo;
         ADDR_LOWER_HI: rd_data = regs.lower_hi;
         ADDR_LOWER_LO: rd_data = regs.lower_lo;
         ADDR_PERSIST: rd_data = regs.persist;
         ADDR_GREEN_ADJ: rd_data = regs.green_adj;
         ADDR_IR_ADJ: rd_data = regs.ir_adj;
         default: rd_data = '0;
      endcase
   end

   // host writes; reserved bits are masked so they read back zero
   always_comb begin
      next_regs = regs;
      if (req.wr) begin
         case (req.addr)
            ADDR_MAIN_CFG: next_regs.main_cfg = req.wdata & MASK_MAIN_CFG;
            ADDR_RECV_CFG: next_regs.recv_cfg = req.wdata & MASK_RECV_CFG;
            ADDR_UPPER_HI: next_regs.upper_hi = req.wdata & MASK_HIGH_BYTE;
            ADDR_UPPER_LO: next_regs.upper_lo = req.wdata;
            ADDR_LOWER_HI: next_regs.lower_hi = req.wdata & MASK_HIGH_BYTE;
            ADDR_LOWER_LO: next_regs.lower_lo = req.wdata;
            ADDR_PERSIST: next_regs.persist = req.wdata & MASK_PERSIST;
            ADDR_GREEN_ADJ: next_regs.green_adj = req.wdata;
            ADDR_IR_ADJ: next_regs.ir_adj = req.wdata;
            default: next_regs = regs;
         endcase
      end
   end

   // gain scaling; products are wide enough that no bits are lost before the shift
   always_comb begin
      green_gain = trim_select ? FACTORY_GREEN : regs.green_adj[7:1];
      ir_gain = trim_select ? FACTORY_IR : {regs.ir_adj, regs.green_adj[0]};
      green_scaled = (23'(green_raw) * 23'(green_gain)) >> GREEN_SHIFT;
      ir_scaled = (23'(infrared_raw) * 23'(ir_gain)) >> IR_SHIFT;
      case (op_mode)
         MODE_GREEN_MINUS_IR:
            value = (green_scaled > ir_scaled) ? green_scaled - ir_scaled : '0;
         MODE_GREEN: value = green_scaled;
         MODE_IR: value = ir_scaled;
         default: value = '0;
      endcase
      new_overflow = value > RESULT_MAX;
      new_result = new_overflow ? RESULT_MAX[RESULT_W-1:0] : value[RESULT_W-1:0];
      out_window = new_result > upper_limit || new_result < lower_limit;
      case (regs.persist[1:0])
         2'h0: persist_need = PERSIST_N0;
         2'h1: persist_need = PERSIST_N1;
         2'h2: persist_need = PERSIST_N2;
         default: persist_need = PERSIST_N3;
      endcase
   end

   // shutdown keeps every register, including the last result
   assign active_sample = sample_valid && op_mode != MODE_SHUTDOWN;

   always_comb begin
      next_light_result = light_result;
      next_result_overflow = result_overflow;
      next_persist_cnt = persist_cnt;
      window_hit = 1'b0;
      if (active_sample) begin
         next_light_result = new_result;
         next_result_overflow = new_overflow;
         if (out_window && persist_cnt < persist_need) begin
            next_persist_cnt = persist_cnt + 5'h01;
         end else if (!out_window) begin
            next_persist_cnt = '0;
         end
         window_hit = new_overflow || (out_window && persist_cnt + 5'h01 >= persist_need);
      end
      if (!light_irq_enable || !next_regs.main_cfg[CFG_EN_BIT]) begin
         // no comparison while disabled, so a stale run cannot fire on re-enable
         next_persist_cnt = '0;
      end
   end

   // a new event in the cycle of a status read wins over the clear
   always_comb begin
      next_power_up_flag = power_up_flag & ~status_read;
      next_light_window_flag = window_hit | (light_window_flag & ~status_read);
      if (!next_regs.main_cfg[CFG_EN_BIT] || !light_irq_enable) begin
         next_light_window_flag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         regs.main_cfg <= RST_MAIN_CFG;
         regs.recv_cfg <= RST_ZERO;
         regs.upper_hi <= RST_ZERO;
         regs.upper_lo <= RST_ZERO;
         regs.lower_hi <= RST_ZERO;
         regs.lower_lo <= RST_ZERO;
         regs.persist <= RST_ZERO;
         regs.green_adj <= RST_GAIN_ADJ;
         regs.ir_adj <= RST_GAIN_ADJ;
         power_up_flag <= RST_STATUS[STAT_PWR_BIT];
         light_window_flag <= RST_STATUS[STAT_WIN_BIT];
         light_result <= '0;
         result_overflow <= 1'b0;
         persist_cnt <= '0;
      end else begin
         regs <= next_regs;
         power_up_flag <= next_power_up_flag;
         light_window_flag <= next_light_window_flag;
         light_result <= next_light_result;
         result_overflow <= next_result_overflow;
         persist_cnt <= next_persist_cnt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   pwr_after_reset_a: assert property ($fell(reset) |-> power_up_flag)
      else $error("power-up flag not set after reset");
   win_set_a: assert property (window_hit && light_irq_enable && next_regs.main_cfg[CFG_EN_BIT]
      |=> light_window_flag)
      else $error("window event did not set flag");
   int_pin_a: assert property ((power_up_flag || light_window_flag) |-> int_n_pin_oe
      ##0 !int_n_pin_out)
      else $error("interrupt pin not pulled low");
   status_clear_a: assert property (status_read && !window_hit |=> !power_up_flag
      && !light_window_flag ##0 !int_n_pin_oe)
      else $error("status read did not clear flags");
   win_disabled_a: assert property (!light_irq_enable |-> !light_window_flag)
      else $error("window flag set while disabled");
   green_only_a: assert property (sample_valid && op_mode == MODE_GREEN
      && green_scaled <= RESULT_MAX |=> light_result == $past(green_scaled))
      else $error("green-only result wrong");
   diff_mode_a: assert property (sample_valid && op_mode == MODE_GREEN_MINUS_IR
      && green_scaled <= ir_scaled |=> light_result == '0)
      else $error("difference not floored at zero");
   ovf_flag_a: assert property (active_sample && new_overflow && light_irq_enable
      && next_regs.main_cfg[CFG_EN_BIT] |=> result_overflow && light_window_flag)
      else $error("overflow did not raise flag");
   shutdown_hold_a: assert property (op_mode == MODE_SHUTDOWN |=> $stable(light_result))
      else $error("result changed in shutdown");
   factory_gain_a: assert property (trim_select |-> green_gain == FACTORY_GREEN
      && ir_gain == FACTORY_IR)
      else $error("factory gains not used");
   trim_write_a: assert property (req.wr && req.addr == ADDR_IR_ADJ
      |=> regs.ir_adj == $past(req.wdata))
      else $error("infrared trim write lost");
   high_byte_a: assert property (req.rd && req.addr == ADDR_RESULT_HI
      |-> rd_data[RES_OVF_BIT] == result_overflow && rd_data[5:0] == light_result[13:8])
      else $error("result high byte layout wrong");
   // disable and persist paths are where a later change slips most easily
   enable_off_a: assert property (req.wr && req.addr == ADDR_MAIN_CFG
      && !req.wdata[CFG_EN_BIT] |=> !light_window_flag && persist_cnt == '0)
      else $error("disable did not clear window state");
   persist_early_a: assert property (active_sample && !new_overflow && !light_window_flag
      && persist_cnt + 5'h01 < persist_need |=> !light_window_flag)
      else $error("window flag before persist count");
   pwr_no_set_a: assert property (!power_up_flag |=> !power_up_flag)
      else $error("power-up flag set without reset");
   status_bits_a: assert property (status_read |-> rd_data[STAT_PWR_BIT] == power_up_flag
      && rd_data[STAT_WIN_BIT] == light_window_flag)
      else $error("status byte layout wrong");
   int_release_a: assert property (!power_up_flag && !light_window_flag |-> !int_n_pin_oe)
      else $error("interrupt pin held without a flag");
   result_load_a: assert property (active_sample |=> light_result == $past(new_result))
      else $error("result not loaded");
   low_byte_a: assert property (req.rd && req.addr == ADDR_RESULT_LO
      |-> rd_data == light_result[7:0])
      else $error("result low byte wrong");
   ir_only_a: assert property (sample_valid && op_mode == MODE_IR && ir_scaled <= RESULT_MAX
      |=> light_result == $past(ir_scaled))
      else $error("infrared-only result wrong");
   user_gain_a: assert property (!trim_select |-> green_gain == regs.green_adj[7:1]
      && ir_gain == {regs.ir_adj, regs.green_adj[0]})
      else $error("user trims not applied");
   green_write_a: assert property (req.wr && req.addr == ADDR_GREEN_ADJ
      |=> regs.green_adj == $past(req.wdata))
      else $error("green trim write lost");
   cfg_write_a: assert property (req.wr && req.addr == ADDR_MAIN_CFG
      |=> regs.main_cfg == ($past(req.wdata) & MASK_MAIN_CFG))
      else $error("configuration write lost");

   status_read_c: cover property (power_up_flag ##1 status_read ##1 !int_n_pin_oe);
   window_event_c: cover property (light_irq_enable && window_hit ##1 light_window_flag);
   reg_write_c: cover property (req.wr && req.addr == ADDR_MAIN_CFG);
   set_beats_clear_c: cover property (status_read && window_hit ##1 light_window_flag);
   persist_hit_c: cover property (active_sample && !new_overflow && window_hit);
endmodule

// ### ls_host_model.sv
`timescale 1ns/1ps
module ls_host_model #(
   parameter int Q = 13
) (
   // clock
   input wire logic clk,
   // bus wires as seen on the board
   input wire logic sda,
   output logic scl,
   output logic sda_oe,
   // interrupt line, active low
   input wire logic int_n
);
   logic [6:0] dev;
   logic [7:0] tx [0:31];
   logic [7:0] rx [0:31];
   logic ack_all;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // scl and sda move only on falling clk edges, a whole phase apart
   task automatic ph(input logic c, input logic d, input int n);
      scl = c;
      sda_oe = d;
      repeat (n) @(negedge clk);
   endtask
   task automatic put_bit(input logic b);
      ph(1'b0, !b, Q);
      ph(1'b1, !b, 2 * Q);
      ph(1'b0, !b, Q);
   endtask
   task automatic get_bit(output logic b);
      ph(1'b0, 1'b0, Q);
      ph(1'b1, 1'b0, Q);
      b = sda;
      ph(1'b1, 1'b0, Q);
      ph(1'b0, 1'b0, Q);
   endtask
   // doubles as repeated start: sda is let go before scl rises
   task automatic start();
      ph(scl, 1'b0, Q);
      ph(1'b1, 1'b0, Q);
      ph(1'b1, 1'b1, Q);
      ph(1'b0, 1'b1, Q);
   endtask
   task automatic stop();
      ph(1'b0, 1'b1, Q);
      ph(1'b1, 1'b1, Q);
      ph(1'b1, 1'b0, 2 * Q);
   endtask
   task automatic wbyte(input logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack_all = ack_all & !b;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(last);
   endtask
   task automatic head(input logic [7:0] idx);
      ack_all = 1'b1;
      start();
      wbyte({dev, 1'b0});
      wbyte(idx);
   endtask
   task automatic wr(input logic [7:0] idx, input int n);
      head(idx);
      for (int i = 0; i < n; i++) begin
         wbyte(tx[i]);
      end
      stop();
   endtask
   task automatic rd(input logic [7:0] idx, input int n);
      head(idx);
      start();
      wbyte({dev, 1'b1});
      for (int i = 0; i < n; i++) begin
         rbyte(i == n - 1, rx[i]);
      end
      stop();
   endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb import ls_pkg::*;;
   localparam logic [6:0] BASE = 7'h2a;
   localparam logic [6:0] FG = 7'h40;
   localparam logic [8:0] FI = 9'h100;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic addr_pin = 1'b1;
   logic sv = 1'b0;
   logic [RESULT_W-1:0] g_raw = '0;
   logic [RESULT_W-1:0] i_raw = '0;
   logic scl, host_oe, sda_out, sda_oe, int_out, int_oe, sda_w, int_w;
   logic [1:0] mode_o, its_o, fgs_o;
   logic [7:0] m [0:16];
   int need_t [0:3] = '{PERSIST_N0, PERSIST_N1, PERSIST_N2, PERSIST_N3};
   int cnt, error_cnt, n_compared, seed;
   assign sda_w = !(sda_oe | host_oe);
   assign int_w = !int_oe;
   always #25 clk = ~clk;
   ls_light_regs #(.TARGET_BASE(BASE), .FACTORY_GREEN(FG), .FACTORY_IR(FI)) dut (
      .clk(clk), .reset(reset), .scl_pin(scl), .sda_pin_in(sda_w),
      .sda_pin_out(sda_out), .sda_pin_oe(sda_oe), .target_addr_select(addr_pin),
      .int_n_pin_out(int_out), .int_n_pin_oe(int_oe), .green_raw(g_raw),
      .infrared_raw(i_raw), .sample_valid(sv), .op_mode(mode_o),
      .integration_time_select(its_o), .front_gain_select(fgs_o));
   ls_host_model #(.Q(13)) host (
      .clk(clk), .sda(sda_w), .scl(scl), .sda_oe(host_oe), .int_n(int_w));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         ADDR_MAIN_CFG: return MASK_MAIN_CFG;
         ADDR_RECV_CFG: return MASK_RECV_CFG;
         ADDR_UPPER_HI, ADDR_LOWER_HI: return MASK_HIGH_BYTE;
         ADDR_PERSIST: return MASK_PERSIST;
         ADDR_UPPER_LO, ADDR_LOWER_LO, ADDR_GREEN_ADJ, ADDR_IR_ADJ: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input int n);
      logic [7:0] x;
      host.wr(a, n);
      for (int i = 0; i < n; i++) begin
         x = 8'(a + i);
         if (wmask(x) != 8'h00) m[x] = host.tx[i] & wmask(x);
         // dropping the enable also drops a pending window event
         if (x == ADDR_MAIN_CFG && !host.tx[i][CFG_EN_BIT]) begin
            m[ADDR_STATUS][STAT_WIN_BIT] = 1'b0;
            cnt = 0;
         end
      end
      check("ack", {7'h00, host.ack_all}, 8'h01);
   endtask
   task automatic rd(input logic [7:0] a, input int n);
      host.rd(a, n);
      for (int i = 0; i < n; i++) begin
         check($sformatf("reg %h", a + i), host.rx[i], m[8'(a + i)]);
         if (8'(a + i) == ADDR_STATUS) m[ADDR_STATUS] = 8'h00;
      end
   endtask
   task automatic chk_int();
      check("int pin", {7'h00, int_w},
         {7'h00, !(m[0][STAT_WIN_BIT] | m[0][STAT_PWR_BIT])});
      check("pin levels", {6'h00, sda_out, int_out}, 8'h00);
   endtask
   task automatic chk_out();
      check("mode", {6'h00, mode_o}, {6'h00, m[ADDR_MAIN_CFG][3:2]});
      check("time", {6'h00, its_o}, {6'h00, m[ADDR_RECV_CFG][3:2]});
      check("gain", {6'h00, fgs_o}, {6'h00, m[ADDR_RECV_CFG][1:0]});
   endtask
   task automatic sample(input int g, input int ir);
      int gs, ip, v;
      logic ovf;
      g_raw = 14'(g);
      i_raw = 14'(ir);
      sv = 1'b1;
      @(negedge clk);
      sv = 1'b0;
      repeat (2) @(negedge clk);
      if (m[1][3:2] == MODE_SHUTDOWN) return;
      gs = m[1][CFG_TRIM_BIT] ? FG : m[ADDR_GREEN_ADJ][7:1];
      ip = m[1][CFG_TRIM_BIT] ? FI : {m[ADDR_IR_ADJ], m[ADDR_GREEN_ADJ][0]};
      gs = (g * gs) >> GREEN_SHIFT;
      ip = (ir * ip) >> IR_SHIFT;
      case (m[1][3:2])
         MODE_GREEN_MINUS_IR: v = gs > ip ? gs - ip : 0;
         MODE_GREEN: v = gs;
         default: v = ip;
      endcase
      ovf = v > RESULT_MAX;
      if (ovf) v = RESULT_MAX;
      m[ADDR_RESULT_HI] = {1'b0, ovf, 6'(v >> 8)};
      m[ADDR_RESULT_LO] = 8'(v);
      if (!m[1][CFG_EN_BIT]) return;
      cnt = (ovf || v > {m[6][5:0], m[7]} || v < {m[8][5:0], m[9]}) ? cnt + 1 : 0;
      if (ovf || cnt >= need_t[m[ADDR_PERSIST][1:0]]) m[0][STAT_WIN_BIT] = 1'b1;
   endtask
   initial begin
      seed = $urandom(32'hd3ec);
      addr_pin = 1'($urandom);
      host.dev = {BASE[6:1], !addr_pin};
      for (int i = 0; i <= 16; i++) begin
         m[i] = 8'h00;
      end
      m[ADDR_STATUS] = RST_STATUS;
      m[ADDR_MAIN_CFG] = RST_MAIN_CFG;
      m[ADDR_GREEN_ADJ] = RST_GAIN_ADJ;
      m[ADDR_IR_ADJ] = RST_GAIN_ADJ;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      chk_int();
      // a foreign address must land nowhere, the reset read below proves it
      host.tx[0] = 8'h01;
      host.wr(ADDR_MAIN_CFG, 1);
      check("foreign ack", {7'h00, host.ack_all}, 8'h00);
      host.dev[0] = addr_pin;
      rd(ADDR_STATUS, 17);
      chk_int();
      chk_out();
      for (int i = 0; i <= 16; i++) begin
         host.tx[i] = 8'($urandom);
      end
      wr(ADDR_STATUS, 17);
      rd(ADDR_STATUS, 17);
      chk_out();
      for (int k = 0; k < 5; k++) begin
         host.tx[0] = {2'h0, 1'(k / 4), 1'b0, 2'((k + 1) % 4), 2'h0};
         wr(ADDR_MAIN_CFG, 1);
         sample($urandom % 8192, $urandom % 8192);
         rd(ADDR_RESULT_HI, 2);
      end
      host.tx[0] = 8'h01;
      host.tx[1] = 8'h00;
      host.tx[2] = 8'h00;
      host.tx[3] = 8'h10;
      wr(ADDR_UPPER_HI, 4);
      host.tx[0] = 8'h29;
      wr(ADDR_MAIN_CFG, 1);
      for (int p = 0; p < 4; p++) begin
         host.tx[0] = 8'(p);
         wr(ADDR_PERSIST, 1);
         sample(8'h80, 0);
         repeat (need_t[p] - 1) sample(16'h0200 + $urandom % 4096, 0);
         sample(8'h80, 0);
         repeat (need_t[p] - 1) sample(16'h0200 + $urandom % 4096, 0);
         chk_int();
         sample(5, 0);
         chk_int();
         rd(ADDR_STATUS, 1);
         chk_int();
      end
      host.tx[0] = 8'h28;
      wr(ADDR_MAIN_CFG, 1);
      repeat (20) sample(14'h3000, 0);
      chk_int();
      rd(ADDR_STATUS, 1);
      host.tx[0] = 8'hff;
      wr(ADDR_GREEN_ADJ, 1);
      host.tx[0] = 8'h09;
      wr(ADDR_MAIN_CFG, 1);
      sample(14'h3fff, 0);
      chk_int();
      rd(ADDR_RESULT_HI, 2);
      host.tx[0] = 8'h08;
      wr(ADDR_MAIN_CFG, 1);
      chk_int();
      rd(ADDR_STATUS, 1);
      conclude();
   end
   // the sequence needs about 81k cycles
   initial begin
      repeat (95000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule
